// >>> core/pss_pkg.sv
// Packet switch buffer scheduler: shared constants, register map and carriers.
// Assumes a single core clock; every link-side struct is sampled on it.
package pss_pkg;
   localparam int NP       = 4;          // Serial ports
   localparam int NPRI     = 4;          // Priority levels
   localparam int NDQ      = 4;          // Queues 0-3 carry data, 4-7 maintenance
   localparam int NQ       = 8;
   localparam int NS       = 8;          // Input tracking slots per queue
   localparam int NO       = 3;          // Output tracking slots per queue
   localparam int NR       = 32;         // Retransmit tracking per priority
   localparam int LW       = 7;          // Packet length field, words
   localparam int GW       = 4;          // Granule count field
   localparam int PMAX     = 3;
   localparam int MAXW     = 70;         // Largest packet, 32-bit words
   localparam int GRANW    = 35;         // Words per allocation granule
   localparam int GMIN     = 2;          // One full packet per priority
   localparam int NGRAN    = 14;         // Seven full packets per port
   localparam int MNTW     = 22;         // 88 bytes per priority
   localparam int OBW      = 112;        // 448 bytes per priority
   localparam int OB_ROOM  = OBW - MAXW;
   localparam int MB_ROOM  = 0;          // A maintenance packet may fill its buffer
   localparam int RBW      = 16 * MAXW;
   localparam int TRK_NORM = 4;
   localparam int TRK_DEEP = 8;
   localparam int PIX_LSB  = 2;
   localparam int PIX_MSB  = 3;
   localparam int RTRY_LSB = 1;
   localparam int RTRY_MSB = 3;
   localparam int DEEP_BIT = 18;
   localparam int ALLOC_W  = NPRI * GW;
   localparam logic [23:0] OPS_ADDR   = 24'hf40004;
   localparam logic [23:0] STAT_ADDR  = 24'hf40008;
   localparam logic [23:0] ALLOC_BASE = 24'hf40010;
   localparam logic [23:0] ALLOC_MASK = 24'hfffff3;
   localparam logic [15:0] ALLOC_RST  = 16'h2228;
   localparam logic [2:0]  RTRY_RST   = 3'h3;

   typedef enum logic [1:0] {RSP_ACC = 2'b00, RSP_CRC = 2'b01, RSP_FLOW = 2'b10} pss_rsp_t;
   typedef enum logic {TX_IDLE = 1'b0, TX_WAIT = 1'b1} pss_tx_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [23:0] addr;
      logic [31:0] wdata;
   } pss_reg_req_t;

   typedef struct packed {
      logic          valid;
      logic          sop;
      logic          eop;
      logic          maint;
      logic [1:0]    prio;
      logic [NP-1:0] dest;
   } pss_rx_t;

   typedef struct packed {
      logic          valid;
      logic [1:0]    prio;
      logic [LW-1:0] len;
   } pss_tx_pkt_t;

   typedef struct packed {
      logic     valid;
      pss_rsp_t kind;
   } pss_rsp_in_t;

   typedef struct packed {
      logic [NP-1:0] mask;
      logic [LW-1:0] len;
   } pss_desc_t;
endpackage: pss_pkg

// >>> core/pss_switch.sv
// Packet switch buffer scheduler: input, output and retransmit buffer accounting
// with the switching scheduler between them.
// Assumes link partners on the same core clock, one word per port per cycle.
`timescale 1ns/1ps
module pss_switch
(
   // Clock and reset
   input  wire logic                                   core_clk,
   input  wire logic                                   rst_n,
   // Register port
   input  wire pss_pkg::pss_reg_req_t                  reg_req,
   output logic [31:0]                                 reg_rdata,
   // Link receive side
   input  wire pss_pkg::pss_rx_t [pss_pkg::NP-1:0]     rx,
   output logic [pss_pkg::NP-1:0]                      rx_retry,
   // Link transmit side
   output pss_pkg::pss_tx_pkt_t [pss_pkg::NP-1:0]      tx,
   input  wire pss_pkg::pss_rsp_in_t [pss_pkg::NP-1:0] rsp,
   output logic [pss_pkg::NP-1:0]                      tx_drop
);
   import pss_pkg::*;

   typedef struct packed {
      logic [2:0]                              rtry_lim;
      logic                                    deep;
      logic [NP-1:0][NPRI-1:0][GW-1:0]         alloc;
      pss_desc_t [NP-1:0][NQ-1:0][NS-1:0]      iq;
      logic [NP-1:0][NQ-1:0][3:0]              icnt;
      logic [NP-1:0][NQ-1:0][8:0]              iocc;
      logic [NP-1:0]                           act;
      logic [NP-1:0][2:0]                      cqi;
      logic [NP-1:0][LW-1:0]                   cw;
      logic [NP-1:0][NP-1:0]                   cd;
      logic [NP-1:0][NQ-1:0][1:0]              rr;
      logic [NP-1:0][NQ-1:0][NO-1:0][LW-1:0]   olen;
      logic [NP-1:0][NQ-1:0][1:0]              ocnt;
      logic [NP-1:0][NQ-1:0][6:0]              oocc;
      logic [NP-1:0][NPRI-1:0][NR-1:0][LW-1:0] rlen;
      logic [NP-1:0][NPRI-1:0][4:0]            rhead;
      logic [NP-1:0][NPRI-1:0][5:0]            rcnt;
      logic [NP-1:0][10:0]                     rocc;
      pss_tx_t [NP-1:0]                        tst;
      logic [NP-1:0][1:0]                      tpr;
      logic [NP-1:0][NPRI-1:0][2:0]            rused;
      logic [NP-1:0]                           rx_retry;
      logic [NP-1:0]                           drop;
      pss_tx_pkt_t [NP-1:0]                    tx;
      logic [31:0]                             rdata;
   } pss_state_t;

   pss_state_t            s;
   pss_state_t            n;
   logic [1:0]            rsync;
   logic                  rst_l;
   logic [NP-1:0][NQ-1:0] ofree;
   logic [NP-1:0]         cval;
   logic [NP-1:0][2:0]    cq;
   logic [NP-1:0][2:0]    cslot;
   logic [NP-1:0][NP-1:0] req;
   logic [NP-1:0][NP-1:0] gnt;

   function automatic logic alloc_ok(input logic [ALLOC_W-1:0] a);
      logic [5:0] sum;
      logic       ok;
      sum = '0;
      ok = 1'b1;
      for (int i = 0; i < NPRI; i++)
      begin
         sum = sum + 6'(a[i*GW +: GW]);
         ok = ok && (a[i*GW +: GW] >= GW'(GMIN));
      end
      return ok && (sum <= 6'(NGRAN));
   endfunction: alloc_ok

   // ==========================================================
   // Scheduler decisions
   always_comb
   begin
      int   top;
      int   bq;
      int   sx;
      logic dn;
      top = 0;
      bq = 0;
      sx = 0;
      dn = 1'b0;
      cval = '0;
      cq = '0;
      cslot = '0;
      req = '0;
      gnt = '0;
      for (int d = 0; d < NP; d++)
         for (int q = 0; q < NQ; q++)
            ofree[d][q] = (s.ocnt[d][q] < 2'(NO))
               && (s.oocc[d][q] <= ((q < NDQ) ? 7'(OB_ROOM) : 7'(MB_ROOM)));
      for (int p = 0; p < NP; p++)
      begin
         // Highest queue index wins: maintenance above data, then priority
         top = -1;
         for (int q = 0; q < NQ; q++)
            if (s.icnt[p][q] != '0)
               top = q;
         if (top >= 0)
         begin
            cq[p] = 3'(top);
            // Descending walk so the oldest servable packet is chosen; in deep mode a data queue offers only its head
            for (int i = NS - 1; i >= 0; i--)
               for (int d = 0; d < NP; d++)
                  if (i < int'(s.icnt[p][top]) && (i == 0 || !(s.deep && top < NDQ))
                      && s.iq[p][top][i].mask[d] && ofree[d][top])
                  begin
                     cval[p] = 1'b1;
                     cslot[p] = 3'(i);
                  end
         end
      end
      for (int d = 0; d < NP; d++)
         for (int p = 0; p < NP; p++)
            req[d][p] = cval[p] && s.iq[p][cq[p]][cslot[p]].mask[d] && ofree[d][cq[p]];
      for (int d = 0; d < NP; d++)
      begin
         bq = -1;
         for (int p = 0; p < NP; p++)
            if (req[d][p] && int'(cq[p]) > bq)
               bq = int'(cq[p]);
         dn = 1'b0;
         if (bq >= 0)
            for (int k = 1; k <= NP; k++)
            begin
               sx = (int'(s.rr[d][bq]) + k) % NP;
               if (!dn && req[d][sx] && int'(cq[sx]) == bq)
               begin
                  gnt[d][sx] = 1'b1;
                  dn = 1'b1;
               end
            end
      end
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      logic [2:0]    q;
      logic [1:0]    hp;
      logic [1:0]    mx;
      logic          hv;
      logic          go;
      logic          pop;
      logic [10:0]   need;
      logic [4:0]    ix;
      logic [9:0]    cap;
      logic [NP-1:0] gm;
      logic [LW-1:0] ln;
      q = '0;
      hp = '0;
      mx = '0;
      hv = 1'b0;
      go = 1'b0;
      pop = 1'b0;
      need = '0;
      ix = '0;
      cap = '0;
      gm = '0;
      ln = '0;
      n = s;
      n.rx_retry = '0;
      n.drop = '0;
      n.tx = '0;

      // ==========================================================
      // Register port
      if (reg_req.wr && reg_req.addr == OPS_ADDR)
      begin
         n.rtry_lim = reg_req.wdata[RTRY_MSB:RTRY_LSB];
         n.deep = reg_req.wdata[DEEP_BIT];
      end
      // A split that starves a priority or overflows the port is ignored
      if (reg_req.wr && (reg_req.addr & ALLOC_MASK) == ALLOC_BASE
          && alloc_ok(reg_req.wdata[ALLOC_W-1:0]))
         n.alloc[reg_req.addr[PIX_MSB:PIX_LSB]] = reg_req.wdata[ALLOC_W-1:0];
      if (reg_req.rd)
      begin
         n.rdata = '0;
         if (reg_req.addr == OPS_ADDR)
         begin
            n.rdata[RTRY_MSB:RTRY_LSB] = s.rtry_lim;
            n.rdata[DEEP_BIT] = s.deep;
         end
         if ((reg_req.addr & ALLOC_MASK) == ALLOC_BASE)
            n.rdata[ALLOC_W-1:0] = s.alloc[reg_req.addr[PIX_MSB:PIX_LSB]];
         if (reg_req.addr == STAT_ADDR)
            for (int p = 0; p < NP; p++)
            begin
               n.rdata[p] = |s.icnt[p];
               n.rdata[NP + p] = (s.tst[p] == TX_WAIT);
            end
      end

      // ==========================================================
      // Output buffer to retransmit buffer, then transmitter
      for (int d = 0; d < NP; d++)
      begin
         hv = 1'b0;
         hp = '0;
         for (int r = 0; r < NPRI; r++)
            if (s.rcnt[d][r] != '0)
            begin
               hv = 1'b1;
               hp = 2'(r);
            end
         go = 1'b0;
         for (int qq = NQ - 1; qq >= 0; qq--)
         begin
            q = 3'(qq);
            mx = (hv && hp > q[1:0]) ? hp : q[1:0];
            need = 11'(s.olen[d][qq][0]) + 11'(MAXW) * 11'(2'(PMAX) - mx);
            if (!go && s.ocnt[d][qq] != '0 && s.rcnt[d][q[1:0]] < 6'(NR)
                && s.rocc[d] + need <= 11'(RBW))
            begin
               go = 1'b1;
               ix = s.rhead[d][q[1:0]] + 5'(s.rcnt[d][q[1:0]]);
               n.rlen[d][q[1:0]][ix] = s.olen[d][qq][0];
               n.rcnt[d][q[1:0]] = s.rcnt[d][q[1:0]] + 6'h01;
               n.rocc[d] = s.rocc[d] + 11'(s.olen[d][qq][0]);
               n.olen[d][qq] = s.olen[d][qq] >> LW;
               n.ocnt[d][qq] = s.ocnt[d][qq] - 2'h1;
               n.oocc[d][qq] = s.oocc[d][qq] - s.olen[d][qq][0];
            end
         end
         pop = 1'b0;
         unique case (s.tst[d])
            TX_IDLE:
               if (hv)
               begin
                  // Always the highest priority held, also after any refusal
                  n.tx[d].valid = 1'b1;
                  n.tx[d].prio = hp;
                  n.tx[d].len = s.rlen[d][hp][s.rhead[d][hp]];
                  n.tpr[d] = hp;
                  n.tst[d] = TX_WAIT;
               end
            TX_WAIT:
               if (rsp[d].valid)
               begin
                  n.tst[d] = TX_IDLE;
                  unique case (rsp[d].kind)
                     RSP_ACC:
                        pop = 1'b1;
                     RSP_CRC:
                        if (s.rused[d][s.tpr[d]] == s.rtry_lim)
                        begin
                           pop = 1'b1;
                           n.drop[d] = 1'b1;
                        end
                        else
                           n.rused[d][s.tpr[d]] = s.rused[d][s.tpr[d]] + 3'h1;
                     RSP_FLOW:
                        pop = 1'b0;
                     default:
                        pop = 1'b0;
                  endcase
               end
         endcase
         if (pop)
         begin
            ln = s.rlen[d][s.tpr[d]][s.rhead[d][s.tpr[d]]];
            n.rhead[d][s.tpr[d]] = s.rhead[d][s.tpr[d]] + 5'h01;
            n.rcnt[d][s.tpr[d]] = n.rcnt[d][s.tpr[d]] - 6'h01;
            n.rocc[d] = n.rocc[d] - 11'(ln);
            n.rused[d][s.tpr[d]] = '0;
         end
      end

      // ==========================================================
      // Switching core: granted descriptors move to output buffers
      for (int p = 0; p < NP; p++)
      begin
         gm = '0;
         for (int d = 0; d < NP; d++)
            gm[d] = gnt[d][p];
         q = cq[p];
         ln = s.iq[p][q][cslot[p]].len;
         if (gm != '0)
         begin
            for (int d = 0; d < NP; d++)
               if (gm[d])
               begin
                  n.olen[d][q][n.ocnt[d][q]] = ln;
                  n.ocnt[d][q] = n.ocnt[d][q] + 2'h1;
                  n.oocc[d][q] = n.oocc[d][q] + ln;
                  n.rr[d][q] = 2'(p);
               end
            n.iq[p][q][cslot[p]].mask = s.iq[p][q][cslot[p]].mask & ~gm;
            // Entry holds its space until the last destination is served
            if ((s.iq[p][q][cslot[p]].mask & ~gm) == '0)
            begin
               for (int i = 0; i < NS - 1; i++)
                  if (i >= int'(cslot[p]))
                     n.iq[p][q][i] = s.iq[p][q][i + 1];
               n.iq[p][q][NS-1] = '0;
               n.icnt[p][q] = s.icnt[p][q] - 4'h1;
               n.iocc[p][q] = s.iocc[p][q] - 9'(ln);
            end
         end
      end

      // ==========================================================
      // Input admission, word by word
      for (int p = 0; p < NP; p++)
      begin
         q = rx[p].sop ? {rx[p].maint, rx[p].prio} : s.cqi[p];
         cap = (q < 3'(NDQ)) ? 10'(GRANW) * 10'(s.alloc[p][q[1:0]]) : 10'(MNTW);
         go = (10'(n.iocc[p][q]) < cap);
         if (rx[p].valid && rx[p].sop)
         begin
            if (go && s.icnt[p][q] < ((q < 3'(NDQ) && s.deep) ? 4'(TRK_DEEP) : 4'(TRK_NORM)))
            begin
               n.act[p] = 1'b1;
               n.cqi[p] = q;
               n.cw[p] = 7'h01;
               n.cd[p] = rx[p].dest;
               n.iocc[p][q] = n.iocc[p][q] + 9'h001;
            end
            else
               n.rx_retry[p] = 1'b1;
         end
         else if (rx[p].valid && s.act[p])
         begin
            if (go && s.cw[p] < 7'(MAXW))
            begin
               n.cw[p] = s.cw[p] + 7'h01;
               n.iocc[p][q] = n.iocc[p][q] + 9'h001;
            end
            else
            begin
               // Abort mid-packet: give back every word taken so far
               n.iocc[p][q] = n.iocc[p][q] - 9'(s.cw[p]);
               n.act[p] = 1'b0;
               n.rx_retry[p] = 1'b1;
            end
         end
         if (rx[p].valid && rx[p].eop && n.act[p])
         begin
            n.act[p] = 1'b0;
            if (n.cd[p] == '0)
               n.iocc[p][q] = n.iocc[p][q] - 9'(n.cw[p]);
            else
            begin
               n.iq[p][q][3'(n.icnt[p][q])] = '{mask: n.cd[p], len: n.cw[p]};
               n.icnt[p][q] = n.icnt[p][q] + 4'h1;
            end
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rsync <= '0;
      else
         rsync <= {rsync[0], 1'b1};
   end

   assign rst_l = rsync[1];

   always_ff @(posedge core_clk or negedge rst_l)
   begin
      if (!rst_l)
      begin
         s <= '0;
         s.alloc <= {NP{ALLOC_RST}};
         s.rtry_lim <= RTRY_RST;
      end
      else
         s <= n;
   end

   assign reg_rdata = s.rdata;
   assign rx_retry = s.rx_retry;
   assign tx = s.tx;
   assign tx_drop = s.drop;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_l);

   property p_retry_cause;
      s.rx_retry[2] |-> $past(rx[2].valid);
   endproperty
   a_retry_cause: assert property (p_retry_cause) else $error("retry without a word");

   property p_track;
      s.icnt[0][0] <= 4'(TRK_DEEP) && s.icnt[0][NDQ] <= 4'(TRK_NORM);
   endproperty
   a_track: assert property (p_track) else $error("input tracking overrun");

   property p_outbuf;
      s.ocnt[1][0] <= 2'(NO) && s.oocc[1][0] <= 7'(OBW) && s.oocc[0][NDQ] <= 7'(MNTW);
   endproperty
   a_outbuf: assert property (p_outbuf) else $error("output buffer overrun");

   property p_rb_space;
      s.rocc[1] <= 11'(RBW) && s.rcnt[1][0] <= 6'(NR);
   endproperty
   a_rb_space: assert property (p_rb_space) else $error("retransmit overrun");

   property p_alloc_floor;
      s.alloc[0][1] >= GW'(GMIN) && s.alloc[0][0] >= GW'(GMIN);
   endproperty
   a_alloc_floor: assert property (p_alloc_floor) else $error("priority lost its packet");

   property p_high_first;
      s.tx[1].valid |-> ($past(s.rcnt[1][PMAX]) == '0 || s.tx[1].prio == 2'(PMAX));
   endproperty
   a_high_first: assert property (p_high_first) else $error("higher priority skipped");

   property p_drop_cause;
      s.drop[1] |-> $past(rsp[1].valid && rsp[1].kind == RSP_CRC && s.tst[1] == TX_WAIT);
   endproperty
   a_drop_cause: assert property (p_drop_cause) else $error("discard without checksum");

   property p_flow_resend;
      (s.tst[1] == TX_WAIT && rsp[1].valid && rsp[1].kind == RSP_FLOW)
         |=> s.tst[1] == TX_IDLE ##1 s.tx[1].valid;
   endproperty
   a_flow_resend: assert property (p_flow_resend) else $error("flow refusal not resent");

   property p_rr_move;
      gnt[0][3] |=> s.rr[0][$past(cq[3])] == 2'h3;
   endproperty
   a_rr_move: assert property (p_rr_move) else $error("pointer did not advance");

   c_retry: cover property (s.rx_retry[2]);
   c_drop: cover property (s.drop[1]);
   c_multicast: cover property (gnt[1][0] && gnt[2][0]);
   c_contend: cover property (req[0][1] && req[0][2]);
endmodule: pss_switch

// >>> bench/pss_link_partner.sv
// Link partner model for one serial port: answers each sent packet.
// Assumes one outstanding packet per port, as the transmitter keeps.
`timescale 1ns/1ps
module pss_link_partner
   import pss_pkg::*;
#(
   parameter int DLY = 3
)
(
   // Clock
   input  wire logic                 core_clk,
   // Link
   input  wire pss_pkg::pss_tx_pkt_t tx,
   output pss_pkg::pss_rsp_in_t      rsp,
   // Bench control
   input  wire logic [3:0]           n_refuse,
   input  wire pss_pkg::pss_rsp_t    refuse_kind,
   input  wire logic                 clr
);
   int          wait_cnt = -1;
   logic [3:0]  refused  = 4'h0;
   pss_rsp_in_t rsp_q    = '0;
   assign rsp = rsp_q;
   always @(posedge core_clk)
   begin
      if (wait_cnt == 0)
      begin
         wait_cnt    <= -1;
         rsp_q.valid <= 1'b1;
         rsp_q.kind  <= (refused < n_refuse) ? refuse_kind : RSP_ACC;
         refused     <= (refused < n_refuse) ? refused + 4'h1 : 4'h0;
      end
      else
      begin
         rsp_q.valid <= 1'b0;
         // Idle code toggles so a stale answer never looks like a fresh one
         rsp_q.kind  <= pss_rsp_t'(~rsp_q.kind);
         if (clr)
            refused <= 4'h0;
         if (tx.valid)
            wait_cnt <= DLY;
         else if (wait_cnt > 0)
            wait_cnt <= wait_cnt - 1;
      end
   end
endmodule: pss_link_partner

// >>> bench/packet_switch_buffer_scheduler_tb_top.sv
// Bench for the packet switch: register rows, then link traffic cases.
// Assumes one partner model per port, each answering at its own pace.
`timescale 1ns/1ps
module packet_switch_buffer_scheduler_tb_top;
   import pss_pkg::*;
   typedef struct {logic w; logic [23:0] a; logic [31:0] d; logic [31:0] e;} pss_row_t;
   logic                 core_clk    = 1'b0;
   logic                 rst_n       = 1'b1;
   pss_reg_req_t         reg_req     = '0;
   logic [31:0]          reg_rdata;
   pss_rx_t [NP-1:0]     rx          = '0;
   logic [NP-1:0]        rx_retry;
   pss_tx_pkt_t [NP-1:0] tx;
   wire pss_rsp_in_t [NP-1:0] rsp;
   logic [NP-1:0]        tx_drop;
   logic [3:0]           n_refuse    = 4'h0;
   pss_rsp_t             refuse_kind = RSP_ACC;
   logic                 clr         = 1'b0;
   int                   mismatches  = 0;
   int                   num_checks  = 0;
   int                   tx_cnt [NP] = '{default: 0};
   int                   drop_cnt [NP] = '{default: 0};
   int                   retry_cnt [NP] = '{default: 0};
   pss_tx_pkt_t          last_tx [NP];
   int                   b;
   pss_row_t rows [7] = '{
      '{1'b1, OPS_ADDR, 32'h0004000a, 32'h0004000a},
      '{1'b1, ALLOC_BASE, 32'h2226, 32'h2226},
      '{1'b1, ALLOC_BASE, 32'h2216, 32'h2226},
      '{1'b1, ALLOC_BASE, 32'h2628, 32'h2226},
      '{1'b1, ALLOC_BASE, 32'h2228, 32'h2228},
      '{1'b0, 24'hf40100, 32'h0, 32'h0},
      '{1'b1, OPS_ADDR, 32'h2, 32'h2}};
   // ====================
   // Design and partners
   pss_switch u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .rx(rx), .rx_retry(rx_retry), .tx(tx), .rsp(rsp),
      .tx_drop(tx_drop));
   for (genvar g = 0; g < NP; g++)
   begin : g_lp
      pss_link_partner #(.DLY(1 + 4 * g)) u_lp (.core_clk(core_clk), .tx(tx[g]),
         .rsp(rsp[g]), .n_refuse(n_refuse), .refuse_kind(refuse_kind), .clr(clr));
   end
   initial forever #10 core_clk = ~core_clk;
   always @(posedge core_clk)
      for (int p = 0; p < NP; p++)
      begin
         drop_cnt[p] += (tx_drop[p] === 1'b1);
         retry_cnt[p] += (rx_retry[p] === 1'b1);
         if (tx[p].valid === 1'b1)
         begin
            tx_cnt[p]++;
            last_tx[p] = tx[p];
         end
      end
   // ====================
   // Tasks
   task automatic tick(input int n = 1);
      repeat (n) @(posedge core_clk);
      #2;
   endtask: tick
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask: check
   task automatic reg_acc(input logic w, input logic [23:0] a, input logic [31:0] d);
      reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
      tick();
      reg_req = '0;
      tick(2);
   endtask: reg_acc
   task automatic send(input int p, input logic m, input logic [1:0] pr,
                       input logic [NP-1:0] ds, input int len);
      for (int i = 0; i < len; i++)
      begin
         rx[p] = '{1'b1, i == 0, i == len - 1, m, pr, ds};
         tick();
      end
      rx[p] = '0;
   endtask: send
   task automatic setp(input logic [3:0] n, input pss_rsp_t k);
      n_refuse = n;
      refuse_kind = k;
      clr = 1'b1;
      tick();
      clr = 1'b0;
   endtask: setp
   task automatic await(input bit drp, input int p, input int target);
      for (int i = 0; i < 3000 && (drp ? drop_cnt[p] : tx_cnt[p]) < target; i++)
         tick();
      if ((drp ? drop_cnt[p] : tx_cnt[p]) < target)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, tx_cnt[p], target);
      end
   endtask: await
   task automatic results;
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask: results
   // ====================
   // Tests
   initial
   begin
      // A real falling edge, so the reset flops leave the unknown state at once
      #1;
      rst_n = 1'b0;
      tick(16);
      rst_n = 1'b1;
      tick(3);
      reg_acc(1'b0, OPS_ADDR, 32'h0);
      check(reg_rdata, 32'h6);
      reg_acc(1'b0, ALLOC_BASE + 24'h4, 32'h0);
      check(reg_rdata, {16'h0, ALLOC_RST});
      $display("test reset done");
      foreach (rows[i])
      begin
         if (rows[i].w)
            reg_acc(1'b1, rows[i].a, rows[i].d);
         reg_acc(1'b0, rows[i].a, 32'h0);
         check(reg_rdata, rows[i].e);
      end
      $display("test rows done");
      setp(4'h2, RSP_FLOW);
      b = tx_cnt[1];
      send(0, 1'b0, 2'h2, 4'b0010, 3);
      await(1'b0, 1, b + 3);
      reg_acc(1'b0, STAT_ADDR, 32'h0);
      check(reg_rdata, 32'h1 << (NP + 1));
      // Let the last answer land before the partner is set up again
      tick(20);
      check(tx_cnt[1] - b, 3);
      check(last_tx[1], {1'b1, 2'h2, 7'd3});
      check(drop_cnt[1], 0);
      $display("test flow done");
      setp(4'hf, RSP_CRC);
      b = tx_cnt[1];
      send(0, 1'b0, 2'h1, 4'b0010, 2);
      await(1'b1, 1, 1);
      check(tx_cnt[1] - b, 2);
      $display("test checksum done");
      setp(4'h0, RSP_ACC);
      b = tx_cnt[3];
      send(0, 1'b0, 2'h0, 4'b1110, 4);
      await(1'b0, 3, b + 1);
      for (int p = 1; p < NP; p++)
         check(last_tx[p], {1'b1, 2'h0, 7'd4});
      send(3, 1'b1, 2'h0, 4'b0001, 5);
      await(1'b0, 0, 1);
      check(last_tx[0], {1'b1, 2'h0, 7'd5});
      $display("test multicast done");
      send(2, 1'b0, 2'h0, 4'b0010, 71);
      tick(3);
      check(retry_cnt[2], 1);
      b = tx_cnt[1];
      send(2, 1'b0, 2'h0, 4'b0010, 70);
      await(1'b0, 1, b + 1);
      check(last_tx[1], {1'b1, 2'h0, 7'd70});
      check(retry_cnt[2], 1);
      $display("test length done");
      results();
   end
   initial
   begin
      #400_000;
      mismatches++;
      results();
   end
endmodule: packet_switch_buffer_scheduler_tb_top
